//--- hw/axi_lite_port.v
// axi4-lite slave front end that turns bus traffic into register strobes
`timescale 1ns/1ps
`include "flash_map.vh"

module axi_lite_port (
    input  wire                sys_clk,
    input  wire                rst,
    input  wire                ce,
    input  wire [`AXI_AW-1:0]  s_axi_awaddr,
    input  wire                s_axi_awvalid,
    output wire                s_axi_awready,
    input  wire [31:0]         s_axi_wdata,
    input  wire [3:0]          s_axi_wstrb,
    input  wire                s_axi_wvalid,
    output wire                s_axi_wready,
    output reg  [1:0]          s_axi_bresp,
    output reg                 s_axi_bvalid,
    input  wire                s_axi_bready,
    input  wire [`AXI_AW-1:0]  s_axi_araddr,
    input  wire                s_axi_arvalid,
    output wire                s_axi_arready,
    output reg  [31:0]         s_axi_rdata,
    output reg  [1:0]          s_axi_rresp,
    output reg                 s_axi_rvalid,
    input  wire                s_axi_rready,
    output wire                reg_wr,
    output wire [`AXI_AW-1:0]  reg_waddr,
    output wire [31:0]         reg_wdata,
    output wire [3:0]          reg_wstrb,
    input  wire                reg_werr,
    output wire [`AXI_AW-1:0]  reg_raddr,
    input  wire [31:0]         reg_rdata,
    input  wire                reg_rerr
);
    reg                aw_got_r;
    reg                w_got_r;
    reg [`AXI_AW-1:0]  awaddr_r;
    reg [31:0]         wdata_r;
    reg [3:0]          wstrb_r;

    assign s_axi_awready = ce & ~aw_got_r & ~s_axi_bvalid;
    assign s_axi_wready  = ce & ~w_got_r & ~s_axi_bvalid;
    assign s_axi_arready = ce & ~s_axi_rvalid;
    wire aw_fire = s_axi_awvalid & s_axi_awready;
    wire w_fire  = s_axi_wvalid & s_axi_wready;
    assign reg_wr    = (aw_got_r | aw_fire) & (w_got_r | w_fire);
    assign reg_waddr = aw_got_r ? awaddr_r : s_axi_awaddr;
    assign reg_wdata = w_got_r ? wdata_r : s_axi_wdata;
    assign reg_wstrb = w_got_r ? wstrb_r : s_axi_wstrb;
    assign reg_raddr = s_axi_araddr;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            awaddr_r     <= {`AXI_AW{1'b0}};
            wdata_r      <= 32'h0000_0000;
            wstrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else if (ce) begin
            if (reg_wr) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= reg_werr ? `RESP_SLVERR : `RESP_OKAY;
            end else begin
                if (aw_fire) begin
                    aw_got_r <= 1'b1;
                    awaddr_r <= s_axi_awaddr;
                end
                if (w_fire) begin
                    w_got_r <= 1'b1;
                    wdata_r <= s_axi_wdata;
                    wstrb_r <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= reg_rdata;
                s_axi_rresp  <= reg_rerr ? `RESP_SLVERR : `RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

//--- hw/flash_cell_array.v
// byte-wide nonvolatile cell storage with program and bulk erase
`timescale 1ns/1ps
`include "flash_map.vh"

module flash_cell_array (
    input  wire        sys_clk,
    input  wire        ce,
    input  wire [14:0] rd_idx,
    output wire [15:0] rd_word,
    input  wire        prog_pulse,
    input  wire [14:0] prog_idx,
    input  wire [15:0] prog_data,
    input  wire        prog_word,
    input  wire        erase_pulse,
    input  wire        boot_protect
);
    reg  [7:0]  cell_r [0:`ARRAY_BYTES-1];
    wire [14:0] rd_next   = rd_idx + 15'd1;
    wire [14:0] prog_next = prog_idx | 15'd1;
    wire        prog_boot = prog_idx[14:11] == `BOOT_BLK_TAG;
    integer     i;

    assign rd_word = {cell_r[rd_idx], cell_r[rd_next]};

    // unprogrammed cells hold ones
    initial begin
        for (i = 0; i < `ARRAY_BYTES; i = i + 1) begin
            cell_r[i] = `ERASED_BYTE;
        end
    end

    always @(posedge sys_clk) begin
        if (ce && erase_pulse) begin
            for (i = 0; i < `ARRAY_BYTES; i = i + 1) begin
                if (!boot_protect || (i < 30720)) begin
                    cell_r[i] <= `ERASED_BYTE;
                end
            end
        end else if (ce && prog_pulse && !(boot_protect && prog_boot)) begin
            // and-ing only clears bits, never sets one
            cell_r[prog_idx] <= cell_r[prog_idx] & prog_data[15:8];
            if (prog_word) begin
                cell_r[prog_next] <= cell_r[prog_next] & prog_data[7:0];
            end
        end
    end
endmodule

//--- hw/flash_ctl.v
// flash program/erase control: registers, array port and interlocks
//
// Contract
// - byte or aligned word access takes one cycle, misaligned word two.
// - with latch off, array writes are dropped and contents stay.
// - blank bits read 1; program clears bits; erase sets them to 1.
// - one program covers one byte or aligned word, by size and bit 0.
// - reprogramming only clears bits; a 0 never returns to 1.
// - with latch on, first valid array write captures address and data.
// - once captured, further array writes are ignored while latch stays.
// - during program or erase, control register writes change only high voltage enable.
// - high voltage enable sets only with latch on and data captured.
// - while high voltage on, clearing latch enable is ignored.
// - while high voltage on, erase select cannot change.
// - with boot protect on, programming the boot block is ignored.
// - after reset the top vector word is fetched from the array.
// - array reads follow high voltage, latch and erase select bits.
// - latch enable cannot set while program voltage is low.
// - setting high voltage with latch negated does nothing.
// - erase pulse blanks whole array, boot block only if unprotected.
`timescale 1ns/1ps
`include "flash_map.vh"

module flash_ctl (
    input  wire                sys_clk,
    input  wire                rst,
    input  wire                ce,
    input  wire [`AXI_AW-1:0]  s_axi_awaddr,
    input  wire                s_axi_awvalid,
    output wire                s_axi_awready,
    input  wire [31:0]         s_axi_wdata,
    input  wire [3:0]          s_axi_wstrb,
    input  wire                s_axi_wvalid,
    output wire                s_axi_wready,
    output wire [1:0]          s_axi_bresp,
    output wire                s_axi_bvalid,
    input  wire                s_axi_bready,
    input  wire [`AXI_AW-1:0]  s_axi_araddr,
    input  wire                s_axi_arvalid,
    output wire                s_axi_arready,
    output wire [31:0]         s_axi_rdata,
    output wire [1:0]          s_axi_rresp,
    output wire                s_axi_rvalid,
    input  wire                s_axi_rready,
    input  wire                arr_req,
    output wire                arr_ready,
    input  wire                arr_wr,
    input  wire                byte_size_signal,
    input  wire [15:0]         arr_addr,
    input  wire [15:0]         arr_wdata,
    output reg  [15:0]         arr_rdata,
    output reg                 arr_ack,
    input  wire                single_chip_mode,
    input  wire                program_voltage_pin,
    output wire                high_voltage_out,
    output reg  [15:0]         boot_vector,
    output reg                 boot_vector_valid
);
    // ==========================================================
    // declarations
    localparam ST_BOOT  = 2'd0;
    localparam ST_IDLE  = 2'd1;
    localparam ST_EXTRA = 2'd2;

    reg  [1:0]          state_r;
    reg                 high_voltage_enable_r;
    reg                 hv_dly_r;
    reg                 latch_enable_r;
    reg                 erase_select_r;
    reg                 boot_block_protect_r;
    reg                 captured_r;
    reg  [14:0]         latched_addr_r;
    reg  [15:0]         latched_data_r;
    reg                 latched_word_r;
    reg                 latch_enable_nxt;
    reg  [14:0]         rd_idx;
    reg  [15:0]         rd_val;
    reg  [31:0]         reg_rdata;
    reg                 reg_rerr;
    reg                 reg_werr;
    wire                reg_wr;
    wire [`AXI_AW-1:0]  reg_waddr;
    wire [31:0]         reg_wdata;
    wire [3:0]          reg_wstrb;
    wire [`AXI_AW-1:0]  reg_raddr;
    wire [15:0]         cell_word;
    wire                ctrl_wr;
    wire                cfg_wr;
    wire                take;
    wire                misalign;
    wire                address_bit_zero;
    wire                valid_addr;
    wire                capture;
    wire                prog_pulse;

    // ==========================================================
    // register bus front end
    axi_lite_port u_axi_lite_port (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .ce            (ce),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .reg_wr        (reg_wr),
        .reg_waddr     (reg_waddr),
        .reg_wdata     (reg_wdata),
        .reg_wstrb     (reg_wstrb),
        .reg_werr      (reg_werr),
        .reg_raddr     (reg_raddr),
        .reg_rdata     (reg_rdata),
        .reg_rerr      (reg_rerr)
    );

    // ==========================================================
    // register decode
    assign ctrl_wr = reg_wr & reg_wstrb[0] & (reg_waddr == `CTRL_OFS);
    assign cfg_wr  = reg_wr & reg_wstrb[0] & (reg_waddr == `CFG_OFS);

    always @* begin
        reg_werr = 1'b0;
        if (reg_waddr == `CTRL_OFS) begin
            reg_werr = 1'b0;
        end else if (reg_waddr == `CFG_OFS) begin
            reg_werr = 1'b0;
        end else if (reg_waddr == `STAT_OFS) begin
            reg_werr = 1'b0;
        end else if (reg_waddr == `VEC_OFS) begin
            reg_werr = 1'b0;
        end else begin
            reg_werr = 1'b1;
        end
    end

    always @* begin
        reg_rdata = 32'h0000_0000;
        reg_rerr  = 1'b0;
        if (reg_raddr == `CTRL_OFS) begin
            reg_rdata[`HVE_BIT]   = high_voltage_enable_r;
            reg_rdata[`LATCH_BIT] = latch_enable_r;
            reg_rdata[`ERASE_BIT] = erase_select_r;
            reg_rdata[`VOK_BIT]   = program_voltage_pin;
        end else if (reg_raddr == `CFG_OFS) begin
            reg_rdata[`BOOT_BLOCK_PROTECT_BIT] = boot_block_protect_r;
        end else if (reg_raddr == `STAT_OFS) begin
            reg_rdata[`CAPT_BIT] = captured_r;
            reg_rdata[`BUSY_BIT] = state_r != ST_IDLE;
        end else if (reg_raddr == `VEC_OFS) begin
            reg_rdata[15:0]           = boot_vector;
            reg_rdata[`VEC_VALID_BIT] = boot_vector_valid;
        end else begin
            reg_rerr = 1'b1;
        end
    end

    // ==========================================================
    // control bits and interlocks
    always @* begin
        latch_enable_nxt = latch_enable_r;
        if (ctrl_wr && !high_voltage_enable_r) begin
            if (!reg_wdata[`LATCH_BIT]) begin
                latch_enable_nxt = 1'b0;
            end else if (program_voltage_pin) begin
                latch_enable_nxt = 1'b1;
            end
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            high_voltage_enable_r <= `CTRL_RST;
            hv_dly_r              <= `CTRL_RST;
            latch_enable_r        <= `CTRL_RST;
            erase_select_r        <= `CTRL_RST;
            boot_block_protect_r  <= `BOOT_BLOCK_PROTECT_RST;
            captured_r            <= 1'b0;
        end else if (ce) begin
            hv_dly_r <= high_voltage_enable_r;
            if (ctrl_wr) begin
                if (high_voltage_enable_r) begin
                    // latch and erase select are frozen meanwhile
                    high_voltage_enable_r <= reg_wdata[`HVE_BIT];
                end else begin
                    high_voltage_enable_r <= reg_wdata[`HVE_BIT]
                        & reg_wdata[`LATCH_BIT]
                        & latch_enable_r & captured_r;
                    erase_select_r <= reg_wdata[`ERASE_BIT];
                end
            end
            latch_enable_r <= latch_enable_nxt;
            if (cfg_wr && !high_voltage_enable_r) begin
                boot_block_protect_r <= reg_wdata[`BOOT_BLOCK_PROTECT_BIT];
            end
            // a fresh latch-enable cycle always starts uncaptured
            captured_r <= latch_enable_nxt & latch_enable_r
                          & (captured_r | capture);
        end
    end

    assign high_voltage_out = high_voltage_enable_r;
    assign prog_pulse = high_voltage_enable_r & ~hv_dly_r;

    // ==========================================================
    // array port decode
    assign arr_ready  = ce & (state_r == ST_IDLE);
    assign take       = arr_req & arr_ready;
    assign address_bit_zero = arr_addr[0];
    assign misalign   = ~byte_size_signal & address_bit_zero;
    assign valid_addr = single_chip_mode & arr_addr[`ARRAY_SEL_BIT];
    assign capture    = take & arr_wr & valid_addr & ~misalign
                        & latch_enable_r & ~captured_r;

    // programming latches
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            latched_addr_r <= 15'h0000;
            latched_data_r <= 16'hffff;
            latched_word_r <= 1'b0;
        end else if (ce && capture) begin
            latched_addr_r <= arr_addr[14:0];
            latched_word_r <= ~byte_size_signal;
            if (byte_size_signal) begin
                latched_data_r <= {arr_wdata[7:0], `ERASED_BYTE};
            end else begin
                latched_data_r <= arr_wdata;
            end
        end
    end

    // ==========================================================
    // read selection
    always @* begin
        rd_idx = arr_addr[14:0];
        rd_val = 16'h0000;
        if (state_r == ST_BOOT) begin
            rd_idx = `TOP_VECTOR_IDX;
        end else if (latch_enable_r && !erase_select_r) begin
            rd_idx = latched_addr_r;
        end
        // with high voltage on the read is ignored and returns zero
        if (!high_voltage_enable_r && valid_addr) begin
            if (byte_size_signal) begin
                rd_val = {8'h00, cell_word[15:8]};
            end else begin
                rd_val = cell_word;
            end
        end
    end

    // ==========================================================
    // access sequencer
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r           <= ST_BOOT;
            arr_ack           <= 1'b0;
            arr_rdata         <= 16'h0000;
            boot_vector       <= 16'h0000;
            boot_vector_valid <= 1'b0;
        end else if (ce) begin
            arr_ack <= 1'b0;
            case (state_r)
                ST_BOOT: begin
                    boot_vector       <= cell_word;
                    boot_vector_valid <= single_chip_mode;
                    state_r           <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (take) begin
                        if (!arr_wr) begin
                            arr_rdata <= rd_val;
                        end
                        if (misalign) begin
                            state_r <= ST_EXTRA;
                        end else begin
                            arr_ack <= 1'b1;
                        end
                    end
                end
                ST_EXTRA: begin
                    arr_ack <= 1'b1;
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // cell storage
    flash_cell_array u_flash_cell_array (
        .sys_clk      (sys_clk),
        .ce           (ce),
        .rd_idx       (rd_idx),
        .rd_word      (cell_word),
        .prog_pulse   (prog_pulse & ~erase_select_r),
        .prog_idx     (latched_addr_r),
        .prog_data    (latched_data_r),
        .prog_word    (latched_word_r),
        .erase_pulse  (prog_pulse & erase_select_r),
        .boot_protect (boot_block_protect_r)
    );
endmodule

//--- pkg/flash_map.vh
// offsets, field positions and reset values of the flash control block
`ifndef FLASH_MAP_VH
`define FLASH_MAP_VH
// ==========================================================
// register byte offsets on the register bus
`define AXI_AW          8
`define CTRL_OFS        8'h00
`define CFG_OFS         8'h04
`define STAT_OFS        8'h08
`define VEC_OFS         8'h0c
// ==========================================================
// field positions
`define HVE_BIT         0
`define LATCH_BIT       1
`define ERASE_BIT       2
`define VOK_BIT         3
`define BOOT_BLOCK_PROTECT_BIT       0
`define CAPT_BIT        0
`define BUSY_BIT        1
`define VEC_VALID_BIT   16
// ==========================================================
// reset values and answers
`define CTRL_RST        1'b0
`define BOOT_BLOCK_PROTECT_RST       1'b0
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
// ==========================================================
// array geometry
`define ARRAY_BYTES     32768
`define ARRAY_SEL_BIT   15
`define TOP_VECTOR_IDX  15'h7ffe
`define BOOT_BLK_TAG    4'hf
`define ERASED_BYTE     8'hff
`endif

//--- verif/cpu_bus_model.sv
// cpu model on the array port: one access at a time
`timescale 1ns/1ps

module cpu_bus_model (
    input  wire         sys_clk,
    input  wire         arr_ready,
    input  wire         arr_ack,
    output logic        arr_req,
    output logic        arr_wr,
    output logic        byte_size_signal,
    output logic [15:0] arr_addr,
    output logic [15:0] arr_wdata
);
    initial {arr_req, arr_wr, byte_size_signal, arr_addr, arr_wdata} = 35'h0;
    // =========
    // idle w cycles, hold until taken, release lines, wait for the ack
    task automatic acc(input logic wr, b, input logic [15:0] a, v,
                       input int w);
        repeat (w) @(posedge sys_clk);
        {arr_req, arr_wr, byte_size_signal} <= {1'b1, wr, b};
        {arr_addr, arr_wdata} <= {a, v};
        do @(posedge sys_clk); while (!arr_ready);
        {arr_req, arr_addr, arr_wdata} <= {1'b0, ~a, ~v};
        do @(posedge sys_clk); while (!arr_ack);
    endtask
endmodule

//--- verif/flash_ctl_assertions.sv
// port-level assertions for the flash control block
`timescale 1ns/1ps

module flash_ctl_assertions (
    input wire        sys_clk,
    input wire        rst,
    input wire        ce,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        arr_req,
    input wire        arr_ready,
    input wire        arr_wr,
    input wire        byte_size_signal,
    input wire [15:0] arr_addr,
    input wire [15:0] arr_rdata,
    input wire        arr_ack,
    input wire        single_chip_mode,
    input wire        high_voltage_out,
    input wire        boot_vector_valid
);
    // =========
    // helpers
    wire take = arr_req && arr_ready;
    wire skew = arr_addr[0] && !byte_size_signal;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst || !ce);
    // =========
    // assertions
    a_aligned_ack: assert property (take && !skew |=> arr_ack)
        else $error("aligned access not acked in one cycle");
    a_misaligned_ack: assert property (take && skew |=>
        !arr_ready && !arr_ack ##1 arr_ack)
        else $error("misaligned access not acked in two cycles");
    a_ack_has_cause: assert property (arr_ack |->
        $past(take) || $past(take, 2))
        else $error("array ack without a request");
    a_hv_read_zero: assert property (take && !arr_wr && !skew &&
        high_voltage_out |=> arr_rdata == 16'h0)
        else $error("array read under high voltage not zero");
    a_rdata_hold: assert property (!(take && !arr_wr) |=>
        $stable(arr_rdata))
        else $error("array read data changed without a read");
    a_hv_by_write: assert property ($rose(high_voltage_out) |->
        $rose(s_axi_bvalid) && s_axi_bresp == 2'h0)
        else $error("high voltage rose without a register write");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid)
        else $error("register read not answered next cycle");
    a_boot_fetch: assert property ($past(rst) && single_chip_mode |=>
        boot_vector_valid)
        else $error("boot vector not fetched after reset");
    c_misaligned: cover property (take && skew);
    c_hv_on: cover property ($rose(high_voltage_out));
    c_hv_read: cover property (take && !arr_wr && high_voltage_out);
endmodule

bind flash_ctl flash_ctl_assertions u_flash_ctl_assertions (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .arr_req(arr_req), .arr_ready(arr_ready), .arr_wr(arr_wr),
    .byte_size_signal(byte_size_signal), .arr_addr(arr_addr),
    .arr_rdata(arr_rdata), .arr_ack(arr_ack),
    .single_chip_mode(single_chip_mode),
    .high_voltage_out(high_voltage_out),
    .boot_vector_valid(boot_vector_valid));

//--- verif/flash_program_erase_control_tb_top.sv
// self-checking bench for the flash program and erase control block
`timescale 1ns/1ps
`include "flash_map.vh"

module flash_program_erase_control_tb_top;
    logic        sys_clk, rst, ce, single_chip_mode, program_voltage_pin;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, arr_req, arr_ready, arr_wr;
    logic        byte_size_signal, arr_ack, high_voltage_out;
    logic        boot_vector_valid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [15:0] arr_addr, arr_wdata, arr_rdata, boot_vector;
    logic [33:0] q[$];
    int          fail_count, compares, seed;

    flash_ctl u_flash_ctl (.*);
    cpu_bus_model u_cpu_bus_model (.*);

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // =========
    // tasks
    task automatic check(input string nm, input logic [33:0] s, e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] r);
        logic aw, w;
        q.push_back({r, 32'h0});
        {s_axi_awaddr, s_axi_wdata} <= {a, v};
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        {aw, w} = 2'h3;
        while (aw || w) begin
            @(posedge sys_clk);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            {s_axi_awvalid, s_axi_wvalid} <= {aw, w};
        end
        do @(posedge sys_clk); while (!s_axi_bvalid);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] r);
        q.push_back({r, v});
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
    endtask
    task automatic cw(input logic [31:0] v);
        wr(`CTRL_OFS, v, `RESP_OKAY);
    endtask
    task automatic ard(input logic b, input logic [15:0] a, e, input int w);
        q.push_back({18'h0, e});
        u_cpu_bus_model.acc(1'b0, b, a, 16'h0, w);
    endtask
    task automatic prog(input logic b, e, input logic [15:0] a, v);
        cw({29'h0, e, 2'h0});
        cw({29'h0, e, 2'h2});
        u_cpu_bus_model.acc(1'b1, b, a, v, 0);
        cw({29'h0, e, 2'h3});
        cw({29'h0, e, 2'h2});
        cw(32'h0);
    endtask
    task automatic summarize();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // =========
    // result monitor
    always @(posedge sys_clk) begin
        if (s_axi_bvalid && s_axi_bready)
            check("bresp", {s_axi_bresp, 32'h0}, q.pop_front());
        if (s_axi_rvalid && s_axi_rready)
            check("rdata", {s_axi_rresp, s_axi_rdata}, q.pop_front());
        if (arr_ack && !arr_wr)
            check("arr_rdata", {18'h0, arr_rdata}, q.pop_front());
    end
    // =========
    // tests
    initial begin
        {seed, fail_count, compares} = {32'd96663, 64'h0};
        {rst, ce, single_chip_mode, program_voltage_pin} = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("boot", {boot_vector_valid, boot_vector}, 34'h1ffff);
        rd(`VEC_OFS, 32'h1ffff, `RESP_OKAY);
        rd(8'h10, 32'h0, `RESP_SLVERR);
        wr(8'h10, 32'h1, `RESP_SLVERR);
        ard(1'b0, 16'h8000, 16'hffff, 0);
        ard(1'b1, 16'h8001, 16'h00ff, 3);
        ard(1'b0, 16'h8001, 16'hffff, 0);
        u_cpu_bus_model.acc(1'b1, 1'b0, 16'h8000, 16'h1234, 0);
        ard(1'b0, 16'h8000, 16'hffff, 0);
        $display("test reads done");
        program_voltage_pin <= 1'b0;
        cw(32'h2);
        rd(`CTRL_OFS, 32'h0, `RESP_OKAY);
        program_voltage_pin <= 1'b1;
        cw(32'h1);
        rd(`CTRL_OFS, 32'h8, `RESP_OKAY);
        cw(32'h2);
        u_cpu_bus_model.acc(1'b1, 1'b0, 16'h8000, 16'ha5c3, 1);
        u_cpu_bus_model.acc(1'b1, 1'b0, 16'h8000, 16'h0000, 0);
        cw(32'h3);
        rd(`CTRL_OFS, 32'hb, `RESP_OKAY);
        ard(1'b0, 16'h8000, 16'h0, 0);
        cw(32'h1);
        cw(32'h7);
        rd(`CTRL_OFS, 32'hb, `RESP_OKAY);
        cw(32'h2);
        ard(1'b0, 16'h8002, 16'ha5c3, 0);
        cw(32'h0);
        ard(1'b0, 16'h8000, 16'ha5c3, 0);
        ard(1'b0, 16'h8002, 16'hffff, 0);
        $display("test interlocks done");
        d = $random(seed);
        prog(1'b0, 1'b0, 16'h8000, d[15:0]);
        ard(1'b0, 16'h8000, 16'ha5c3 & d[15:0], 0);
        prog(1'b1, 1'b0, 16'h8003, d[31:16]);
        ard(1'b1, 16'h8003, {8'h0, d[23:16]}, 2);
        ard(1'b0, 16'h8002, {8'hff, d[23:16]}, 0);
        $display("test reprogram done");
        prog(1'b0, 1'b0, 16'hf800, 16'h0);
        wr(`CFG_OFS, 32'h1, `RESP_OKAY);
        prog(1'b0, 1'b0, 16'hf802, 16'h0);
        ard(1'b0, 16'hf802, 16'hffff, 0);
        prog(1'b0, 1'b1, 16'h9000, d[15:0]);
        ard(1'b0, 16'h8000, 16'hffff, 0);
        ard(1'b0, 16'hf800, 16'h0, 0);
        wr(`CFG_OFS, 32'h0, `RESP_OKAY);
        prog(1'b0, 1'b1, 16'h8000, 16'h0);
        ard(1'b0, 16'hf800, 16'hffff, 0);
        single_chip_mode <= 1'b0;
        ard(1'b0, 16'h8000, 16'h0, 0);
        $display("test boot and erase done");
        summarize();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        $display("Error watchdog expected done seen timeout");
        summarize();
    end
endmodule
